/* rtl/supply_monitor_pkg.sv */
// package: register map, field layout and timing of the supply monitor
package supply_monitor_pkg;
   // register indices; byte address is four times the index
   localparam logic [3:0] IDX_CONTROL_A     = 4'h0;
   localparam logic [3:0] IDX_LEVEL_CONTROL = 4'h1;
   localparam logic [3:0] IDX_MONITOR_LEVEL = 4'h8;
   localparam logic [3:0] IDX_MONITOR_INT   = 4'h9;
   localparam logic [3:0] IDX_MONITOR_FLAGS = 4'ha;
   localparam logic [3:0] IDX_MONITOR_STAT  = 4'hb;
   localparam logic [3:0] IDX_UNLOCK        = 4'hc;
   localparam logic [3:0] IDX_STATE         = 4'hd;
   // key written to the unlock register
   localparam logic [7:0] IO_WRITE_KEY      = 8'hd8;
   localparam logic [2:0] UNLOCK_WINDOW     = 3'h4;
   // field positions
   localparam int SLEEP_LSB   = 0;
   localparam int ACTIVE_LSB  = 2;
   localparam int RATE_BIT    = 4;
   localparam int TRIG_LSB    = 1;
   localparam int IE_BIT      = 0;
   // reset values
   localparam logic [1:0] MONITOR_LEVEL_RESET = 2'h0;
   localparam logic [1:0] TRIGGER_RESET       = 2'h0;
   // mode codes
   typedef enum logic [1:0] {
      MODE_OFF     = 2'b00,
      MODE_ON      = 2'b01,
      MODE_SAMPLED = 2'b10,
      MODE_ON_HOLD = 2'b11
   } mode_type;
   // trigger codes
   localparam logic [1:0] TRIG_FALLING = 2'h0;
   localparam logic [1:0] TRIG_RISING  = 2'h1;
   localparam logic [1:0] TRIG_BOTH    = 2'h2;
   // timing at the 32 kHz detector clock
   localparam int CLOCK_HZ        = 32768;
   localparam int RATE_FAST_HZ    = 1000;
   localparam int RATE_SLOW_HZ    = 125;
   localparam logic [8:0] FAST_PERIOD_CYCLES =
      9'(CLOCK_HZ / RATE_FAST_HZ);
   localparam logic [8:0] SLOW_PERIOD_CYCLES =
      9'(CLOCK_HZ / RATE_SLOW_HZ);
endpackage

/* rtl/supply_drop_detector.sv */
// supply drop detector control with early warning monitor and apb slave
//
// Local design decision: the APB register port.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - logic runs on detector clock, 32 kHz
// - fuse values loaded at reset release
// - threshold and active mode are read-only
// - sleep mode starts fused, stays writable
// - enable bit turns monitor flag and interrupt on
// - trigger selects falling, rising or both
// - disabled detector keeps monitor inactive
// - sampled mode evaluates monitor at samples only
// - enabling with both-edge trigger sets flag
// - monitor threshold chosen by level field
// - sampled mode: only rising-code trigger fires
// - trigger condition sets monitor flag
// - request while enable and flag set
// - sleep uses sleep mode, wake uses active
// - key then write within four clock cycles
// - locked protected write accepted, ignored
// - enabled continuous, sampled pulses per period
// - reset request when supply below threshold
// - debug halt changes nothing here
// - only sleep field writable in control a
// - rate bit: 1 kHz zero, 125 Hz one
// - mode codes off, on, sampled, on-hold
// - level codes 5, 15, 25 percent
// - flag set only when detector enabled, cleared by writing one unless a set lands in the same cycle
module supply_drop_detector
   import supply_monitor_pkg::*;
(
   input  wire logic        CLOCK,
   input  wire logic        ARST_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [5:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic [1:0]  FUSE_SLEEP_MODE,
   input  wire logic [1:0]  FUSE_ACTIVE_MODE,
   input  wire logic        FUSE_RATE,
   input  wire logic [2:0]  FUSE_THRESHOLD,
   input  wire logic        DEEP_SLEEP,
   input  wire logic        SUPPLY_BELOW_DROP,
   input  wire logic        SUPPLY_BELOW_MONITOR,
   output logic             COMPARATOR_ENABLE,
   output logic [2:0]       DROP_THRESHOLD,
   output logic [1:0]       MONITOR_THRESHOLD,
   output logic             DETECTOR_READY,
   output logic             RESET_REQUEST,
   output logic             MONITOR_IRQ
);

   typedef struct packed {
      logic       loaded;
      logic [1:0] sleep_mode;
      logic [1:0] active_mode;
      logic       rate;
      logic [2:0] threshold;
      logic [1:0] level;
      logic [1:0] trigger;
      logic       irq_enable;
      logic       irq_flag;
      logic       below_state;
      logic       state_valid;
      logic [2:0] unlock_count;
      logic [8:0] sample_count;
      logic       strobe;
      logic [2:0] drop_sync;
      logic [2:0] mon_sync;
      logic [2:0] sleep_sync;
      logic       sleep_seen;
      logic       drop_seen;
      logic       mon_seen;
      logic       reset_req;
      logic [31:0] rdata;
   } state_type;

   state_type state_reg;
   state_type state_next;

   logic       wr_access;
   logic       rd_access;
   logic [3:0] index;
   logic       aligned;
   logic [7:0] wbyte;
   mode_type   mode_now;
   logic       running;
   logic       evaluate;
   logic       mon_fell;
   logic       mon_rose;
   logic       trig_hit;
   logic       enable_edge;
   logic       drop_level;
   logic       mon_level;
   logic [8:0] period;
   logic       sleep_level;
   logic       wr_control_a;
   logic       wr_monitor_level;
   logic       wr_monitor_int;
   logic       wr_monitor_flags;
   logic       wr_unlock;
   logic       unlocked;
   logic       monitor_hit;
   logic       enable_sets_flag;
   logic [31:0] rd_value;

   assign index   = PADDR[5:2];
   assign aligned = (PADDR[1:0] == 2'b00);
   assign wbyte   = PWDATA[7:0];
   assign wr_access = PSEL && PENABLE && PWRITE && aligned;
   assign rd_access = PSEL && !PENABLE && !PWRITE;

   // one strobe per writable register on the access-phase edge
   assign wr_control_a     = wr_access && (index == IDX_CONTROL_A);
   assign wr_monitor_level = wr_access && (index == IDX_MONITOR_LEVEL);
   assign wr_monitor_int   = wr_access && (index == IDX_MONITOR_INT);
   assign wr_monitor_flags = wr_access && (index == IDX_MONITOR_FLAGS);
   assign wr_unlock        = wr_access && (index == IDX_UNLOCK);
   assign unlocked         = (state_reg.unlock_count != 3'h0);

   always_comb begin
      if (sleep_level) begin
         mode_now = mode_type'(state_reg.sleep_mode);
      end else begin
         mode_now = mode_type'(state_reg.active_mode);
      end
   end

   always_comb begin
      if (state_reg.rate) begin
         period = SLOW_PERIOD_CYCLES;
      end else begin
         period = FAST_PERIOD_CYCLES;
      end
   end

   assign running = state_reg.loaded && (mode_now != MODE_OFF);

   always_comb begin
      if (!running) begin
         evaluate = 1'b0;
      end else if (mode_now == MODE_SAMPLED) begin
         evaluate = state_reg.strobe;
      end else begin
         evaluate = 1'b1;
      end
   end

   // a change counts once the second and third stages agree
   always_comb begin
      if (state_reg.drop_sync[2] == state_reg.drop_sync[1]) begin
         drop_level = state_reg.drop_sync[1];
      end else begin
         drop_level = state_reg.drop_seen;
      end
      if (state_reg.mon_sync[2] == state_reg.mon_sync[1]) begin
         mon_level = state_reg.mon_sync[1];
      end else begin
         mon_level = state_reg.mon_seen;
      end
      if (state_reg.sleep_sync[2] == state_reg.sleep_sync[1]) begin
         sleep_level = state_reg.sleep_sync[1];
      end else begin
         sleep_level = state_reg.sleep_seen;
      end
   end

   // edges of the settled monitor level against the last evaluation
   always_comb begin
      mon_fell = 1'b0;
      mon_rose = 1'b0;
      if (mon_level && !state_reg.below_state) begin
         mon_fell = 1'b1;
      end
      if (!mon_level && state_reg.below_state) begin
         mon_rose = 1'b1;
      end
   end

   always_comb begin
      trig_hit = 1'b0;
      if (mode_now == MODE_SAMPLED) begin
         trig_hit = (state_reg.trigger == TRIG_RISING) && mon_fell;
      end else begin
         case (state_reg.trigger)
            TRIG_FALLING: trig_hit = mon_fell;
            TRIG_RISING:  trig_hit = mon_rose;
            TRIG_BOTH:    trig_hit = mon_fell || mon_rose;
            default:      trig_hit = 1'b0;
         endcase
      end
   end

   // rising edge of the enable bit, written by this access
   assign enable_edge = wr_monitor_int && wbyte[IE_BIT] &&
                        !state_reg.irq_enable;

   // enabling with the both-ways trigger raises the flag at once
   always_comb begin
      enable_sets_flag = 1'b0;
      if (enable_edge && running) begin
         if (wbyte[TRIG_LSB +: 2] == TRIG_BOTH) begin
            enable_sets_flag = 1'b1;
         end
      end
   end

   // a crossing counts only after one settled evaluation
   always_comb begin
      monitor_hit = 1'b0;
      if (evaluate && state_reg.irq_enable) begin
         monitor_hit = state_reg.state_valid && trig_hit;
      end
   end

   // read data mux, registered at the setup edge
   always_comb begin
      rd_value = 32'h0;
      case (index)
         IDX_CONTROL_A: begin
            rd_value[SLEEP_LSB +: 2]  = state_reg.sleep_mode;
            rd_value[ACTIVE_LSB +: 2] = state_reg.active_mode;
            rd_value[RATE_BIT]        = state_reg.rate;
         end
         IDX_LEVEL_CONTROL: begin
            rd_value[2:0] = state_reg.threshold;
         end
         IDX_MONITOR_LEVEL: begin
            rd_value[1:0] = state_reg.level;
         end
         IDX_MONITOR_INT: begin
            rd_value[TRIG_LSB +: 2] = state_reg.trigger;
            rd_value[IE_BIT]        = state_reg.irq_enable;
         end
         IDX_MONITOR_FLAGS: begin
            rd_value[0] = state_reg.irq_flag;
         end
         IDX_MONITOR_STAT: begin
            rd_value[0] = state_reg.below_state;
         end
         IDX_STATE: begin
            rd_value[2] = unlocked;
            rd_value[1] = running;
            rd_value[0] = state_reg.reset_req;
         end
         default: begin
            rd_value = 32'h0;
         end
      endcase
   end

   always_comb begin
      state_next = state_reg;
      state_next.drop_sync = {state_reg.drop_sync[1:0], SUPPLY_BELOW_DROP};
      state_next.mon_sync  = {state_reg.mon_sync[1:0], SUPPLY_BELOW_MONITOR};
      state_next.drop_seen = drop_level;
      state_next.mon_seen  = mon_level;
      state_next.sleep_sync = {state_reg.sleep_sync[1:0], DEEP_SLEEP};
      state_next.sleep_seen = sleep_level;
      if (!state_reg.loaded) begin
         state_next.loaded      = 1'b1;
         state_next.sleep_mode  = FUSE_SLEEP_MODE;
         state_next.active_mode = FUSE_ACTIVE_MODE;
         state_next.rate        = FUSE_RATE;
         state_next.threshold   = FUSE_THRESHOLD;
      end
      // sampling period counter
      state_next.strobe = 1'b0;
      if (state_reg.sample_count >= period - 9'h1) begin
         state_next.sample_count = 9'h0;
         state_next.strobe       = 1'b1;
      end else begin
         state_next.sample_count = state_reg.sample_count + 9'h1;
      end
      if (state_reg.unlock_count != 3'h0) begin
         state_next.unlock_count = state_reg.unlock_count - 3'h1;
      end
      // monitor evaluation
      if (evaluate) begin
         state_next.below_state = mon_level;
         state_next.state_valid = 1'b1;
         if (monitor_hit) begin
            state_next.irq_flag = 1'b1;
         end
      end else if (!running) begin
         state_next.state_valid = 1'b0;
      end
      // level follows the comparator at evaluation instants
      if (!running) begin
         state_next.reset_req = 1'b0;
      end else if (evaluate) begin
         state_next.reset_req = drop_level;
      end
      // register writes
      if (wr_access) begin
         case (index)
            IDX_CONTROL_A: begin
               if (unlocked) begin
                  state_next.sleep_mode = wbyte[SLEEP_LSB +: 2];
                  state_next.unlock_count = 3'h0;
               end
            end
            IDX_MONITOR_LEVEL: begin
               state_next.level = wbyte[1:0];
            end
            IDX_MONITOR_INT: begin
               state_next.trigger    = wbyte[TRIG_LSB +: 2];
               state_next.irq_enable = wbyte[IE_BIT];
            end
            IDX_MONITOR_FLAGS: begin
               if (wbyte[0]) begin
                  state_next.irq_flag = 1'b0;
               end
            end
            IDX_UNLOCK: begin
               if (wbyte == IO_WRITE_KEY) begin
                  state_next.unlock_count = UNLOCK_WINDOW;
               end
            end
            IDX_LEVEL_CONTROL: begin
            end
            IDX_MONITOR_STAT: begin
               // status follows the monitor only
            end
            default: begin
            end
         endcase
      end
      if (enable_sets_flag || monitor_hit) begin
         state_next.irq_flag = 1'b1;
      end
      // read data captured in setup phase
      if (rd_access) begin
         state_next.rdata = rd_value;
      end
   end

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign PRDATA            = state_reg.rdata;
   assign PREADY            = 1'b1;
   assign PSLVERR           = 1'b0;
   assign COMPARATOR_ENABLE = running &&
      ((mode_now == MODE_SAMPLED) ? state_reg.strobe : 1'b1);
   assign DROP_THRESHOLD    = state_reg.threshold;
   assign MONITOR_THRESHOLD = state_reg.level;
   assign DETECTOR_READY    = state_reg.loaded && state_reg.state_valid;
   assign RESET_REQUEST     = state_reg.reset_req;
   assign MONITOR_IRQ       = state_reg.irq_enable && state_reg.irq_flag;

endmodule
`default_nettype wire

/* bench/supply_drop_detector_monitor.sv */
// port checker for the supply drop detector
`timescale 1ns/1ns
`default_nettype none
module supply_drop_detector_monitor (
   input wire logic        CLOCK,
   input wire logic        ARST_N,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [5:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        SUPPLY_BELOW_DROP,
   input wire logic        COMPARATOR_ENABLE,
   input wire logic [2:0]  DROP_THRESHOLD,
   input wire logic [1:0]  MONITOR_THRESHOLD,
   input wire logic        RESET_REQUEST,
   input wire logic        MONITOR_IRQ
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!ARST_N);
   wire wr_acc = PSEL && PENABLE && PWRITE;
   property p_bus_ok; PSEL |-> PREADY && !PSLVERR; endproperty
   a_bus_ok: assert property (p_bus_ok) else $error("bus answer");
   property p_irq_hold; MONITOR_IRQ && !wr_acc |=> MONITOR_IRQ; endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq drop");
   property p_irq_clear;
      wr_acc && PADDR == 6'h28 && PWDATA[0] |=> !MONITOR_IRQ; endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("irq clr");
   property p_drop_req;
      (SUPPLY_BELOW_DROP && COMPARATOR_ENABLE)[*8] |-> RESET_REQUEST;
   endproperty
   a_drop_req: assert property (p_drop_req) else $error("no req");
   property p_drop_clear;
      (!SUPPLY_BELOW_DROP && COMPARATOR_ENABLE)[*8] |-> !RESET_REQUEST;
   endproperty
   a_drop_clear: assert property (p_drop_clear) else $error("req");
   property p_thr_fixed; wr_acc |=> $stable(DROP_THRESHOLD); endproperty
   a_thr_fixed: assert property (p_thr_fixed) else $error("thr");
   property p_mon_thr; wr_acc && PADDR == 6'h20 && PWDATA[1:0] != 2'h3
      |=> MONITOR_THRESHOLD == $past(PWDATA[1:0]); endproperty
   a_mon_thr: assert property (p_mon_thr) else $error("mon thr");
   property p_level_read; PSEL && !PENABLE && !PWRITE && PADDR == 6'h04
      |=> PRDATA == {29'h0, DROP_THRESHOLD}; endproperty
   a_level_read: assert property (p_level_read) else $error("lvl");
   property p_irq_rise; $rose(MONITOR_IRQ) |-> $past(COMPARATOR_ENABLE);
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("irq off");
endmodule
bind supply_drop_detector supply_drop_detector_monitor u_monitor (
   .CLOCK, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
   .PREADY, .PSLVERR, .SUPPLY_BELOW_DROP, .COMPARATOR_ENABLE,
   .DROP_THRESHOLD, .MONITOR_THRESHOLD, .RESET_REQUEST, .MONITOR_IRQ);
`default_nettype wire

/* bench/tb_supply_drop_detector.sv */
// self-checking bench for the supply drop detector
`timescale 1ns/1ns
`default_nettype none
module tb_supply_drop_detector;
   import supply_monitor_pkg::*;
   logic        clock = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic        deep = 0, below_drop = 0, below_mon = 0, f_rate = 0;
   logic        pready, pslverr, comp_en, ready, reset_req, irq;
   logic [5:0]  paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic [1:0]  f_sleep = '0, f_active = 2'h1, mon_thr;
   logic [2:0]  f_thr = '0, drop_thr;
   int          err_count = 0, compares = 0, n, k, i, exp_reg[16];
   bit          unlocked = 0;
   always #10 clock = ~clock;
   supply_drop_detector u_supply_drop_detector (
      .CLOCK(clock), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .FUSE_SLEEP_MODE(f_sleep),
      .FUSE_ACTIVE_MODE(f_active), .FUSE_RATE(f_rate),
      .FUSE_THRESHOLD(f_thr), .DEEP_SLEEP(deep),
      .SUPPLY_BELOW_DROP(below_drop), .SUPPLY_BELOW_MONITOR(below_mon),
      .COMPARATOR_ENABLE(comp_en), .DROP_THRESHOLD(drop_thr),
      .MONITOR_THRESHOLD(mon_thr), .DETECTOR_READY(ready),
      .RESET_REQUEST(reset_req), .MONITOR_IRQ(irq));
   task automatic conclude;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(logic wr, logic [3:0] idx, logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clock);
      psel <= 1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge clock);
      penable <= 1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n == 50) check("pready", 1, 0);
      if (n == 50) conclude();
      q = prdata;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic wr(logic [3:0] idx, logic [7:0] d);
      logic [31:0] q;
      apb(1, idx, {24'h0, d}, q);
      if (idx == IDX_CONTROL_A && unlocked) exp_reg[0][1:0] = d[1:0];
      if (idx == IDX_MONITOR_LEVEL) exp_reg[8] = d & 3;
      if (idx == IDX_MONITOR_INT) exp_reg[9] = d & 7;
      unlocked = (idx == IDX_UNLOCK && d == IO_WRITE_KEY);
   endtask
   task automatic rd(logic [3:0] idx, logic [31:0] exp);
      logic [31:0] q;
      apb(0, idx, 32'h0, q);
      check($sformatf("register %h", idx), exp, q);
   endtask
   task automatic await(ref logic s, input logic v, input string what);
      for (n = 0; n < 20 && s !== v; n++) @(negedge clock);
      check(what, v, s);
      if (s !== v) conclude();
      @(posedge clock);
   endtask
   initial begin
      void'($urandom(19));
      f_sleep = 2'($urandom % 3);
      f_thr = 3'($urandom);
      exp_reg[0] = {f_rate, f_active, f_sleep};
      exp_reg[1] = f_thr;
      repeat (4) @(posedge clock);
      arst_n <= 1;
      repeat (2) @(posedge clock);
      for (i = 0; i < 12; i++)
         if (i < 2 || i > 7) rd(4'(i), exp_reg[i]);
      rd(4'h5, 0);
      wr(IDX_CONTROL_A, 8'hff);
      wr(IDX_LEVEL_CONTROL, 8'hff);
      wr(IDX_MONITOR_LEVEL, 8'($urandom % 3));
      wr(IDX_UNLOCK, IO_WRITE_KEY);
      wr(IDX_CONTROL_A, 8'hfe);
      for (i = 0; i < 12; i++)
         if (i < 2 || i > 7) rd(4'(i), exp_reg[i]);
      check("drop threshold", f_thr, drop_thr);
      check("monitor threshold", exp_reg[8], mon_thr);
      $display("register test done");
      deep <= 1;
      repeat (8) @(negedge clock);
      k = 0;
      repeat (96) begin
         @(negedge clock);
         k += comp_en;
      end
      check("sample pulses", 3, k);
      @(posedge clock);
      deep <= 0;
      await(comp_en, 1, "comparator on");
      check("detector ready", 1, ready);
      below_drop <= 1;
      await(reset_req, 1, "reset request");
      below_drop <= 0;
      await(reset_req, 0, "reset release");
      $display("mode test done");
      wr(IDX_MONITOR_INT, 8'h01);
      repeat (8) @(posedge clock);
      wr(IDX_MONITOR_FLAGS, 8'h01);
      await(irq, 0, "irq idle");
      below_mon <= 1;
      await(irq, 1, "irq falling");
      rd(IDX_MONITOR_STAT, 1);
      wr(IDX_MONITOR_FLAGS, 8'h00);
      rd(IDX_MONITOR_FLAGS, 1);
      wr(IDX_MONITOR_FLAGS, 8'h01);
      await(irq, 0, "irq cleared");
      wr(IDX_MONITOR_INT, 8'h03);
      below_mon <= 0;
      await(irq, 1, "irq rising");
      wr(IDX_MONITOR_INT, 8'h00);
      wr(IDX_MONITOR_FLAGS, 8'h01);
      wr(IDX_MONITOR_INT, 8'h05);
      await(irq, 1, "irq on enable");
      wr(IDX_MONITOR_INT, 8'h04);
      await(irq, 0, "irq masked");
      rd(IDX_MONITOR_FLAGS, 1);
      wr(IDX_MONITOR_FLAGS, 8'h01);
      wr(IDX_MONITOR_INT, 8'h01);
      wr(IDX_UNLOCK, IO_WRITE_KEY);
      wr(IDX_CONTROL_A, 8'h00);
      deep <= 1;
      repeat (6) @(posedge clock);
      below_mon <= 1;
      repeat (12) @(negedge clock);
      check("irq detector off", 0, irq);
      $display("monitor test done");
      conclude();
   end
endmodule
`default_nettype wire
